// ==== src/lic_line_cfg.sv ====
// line interface configuration bank with signalling event detector and upstream change flag
module lic_line_cfg
   import lic_pkg::*;
#(
   parameter int SIG_W = 6
) (
   input  wire logic               sys_clk,
   input  wire logic               srst,
   input  wire lic_pkg::lic_cmd_t  cmd,
   input  wire logic               status_rd,
   input  wire logic [SIG_W-1:0]   sig_live,
   input  wire logic [9:0]         loop_current_100ua,
   output logic [7:0]              rd_data,
   output logic                    rd_valid,
   output lic_pkg::lic_cfg_t       cfg,
   output logic                    a_law_sel,
   output logic                    loop_indication,
   output logic                    change_flag,
   input  wire logic               link_clk,
   input  wire logic               link_frame_sync,
   output logic                    upstream_change_bit
);
   import lic_pkg::*;

   typedef enum logic [1:0] {
      LIC_EV_ARMED,
      LIC_EV_LATCHED,
      LIC_EV_HOLD
   } lic_ev_t;

   logic [7:0]       bank_reg [LIC_NUM_REGS];
   logic [7:0]       rd_data_reg;
   logic             rd_valid_reg;
   lic_cfg_t         cfg_reg;
   logic             loop_ind_reg;
   lic_ev_t          ev_state_reg;
   logic [SIG_W-1:0] shadow_reg;
   logic [SIG_W-1:0] sig_prev_reg;
   logic [1:0]       hold_cnt_reg;
   logic             wr_hit;
   logic [2:0]       wr_idx;
   logic             rd_hit;
   logic [2:0]       rd_idx;
   logic [SIG_W-1:0] mask_now;
   logic [SIG_W-1:0] mask_next;
   logic             mask_change;
   logic [SIG_W-1:0] enabled;
   logic             sig_event;
   logic             shadow_differs;
   logic [7:0]       status_byte;
   logic             frame_tick;
   logic             ext_a_law_reg;
   logic             flag_sys_reg;

   // link-side signals
   logic             link_rst_s1_reg;
   logic             link_rst_reg;
   logic             fsync_prev_reg;
   logic             frame_tgl_reg;
   logic             flag_s1_reg;
   logic             flag_s2_reg;
   logic             upstream_reg;

   // sys-side capture of the frame toggle
   logic             tgl_s1_reg;
   logic             tgl_s2_reg;
   logic             tgl_s3_reg;

   function automatic logic in_bank(input logic [3:0] a);
      in_bank = (a >= LIC_REG_RING_TRIP_TEST) && (a <= LIC_REG_SIG_MASK_CODING);
   endfunction

   function automatic logic [2:0] bank_idx(input logic [3:0] a);
      logic [3:0] d;
      d = a - LIC_REG_RING_TRIP_TEST;
      bank_idx = d[2:0];
   endfunction

   function automatic logic [7:0] rst_value(input int i);
      logic [7:0] v;
      v = 8'h00;
      case (i)
         0: v = LIC_RST_RING_TRIP_TEST;
         1: v = LIC_RST_ACTIVE_LIMIT;
         2: v = LIC_RST_STANDBY_LIMIT;
         3: v = LIC_RST_FEED_METER;
         4: v = LIC_RST_RING_FREQ_AMP;
         5: v = LIC_RST_METER_LEVEL;
         6: v = LIC_RST_EXT_IND;
         7: v = LIC_RST_SIG_MASK_CODING;
         default: v = 8'h00;
      endcase
      rst_value = v;
   endfunction

   function automatic lic_test_t test_decode(input logic [3:0] c);
      lic_test_t t;
      t = LIC_TEST_NONE;
      case (c)
         4'h1: t = LIC_TEST_LEAK;
         4'h2: t = LIC_TEST_LEAK_ALT;
         4'h4: t = LIC_TEST_800HZ;
         4'h5: t = LIC_TEST_TONE_CAL;
         4'h7: t = LIC_TEST_ANALOG_LOOP;
         4'h9: t = LIC_TEST_LINE_IMP_DC;
         4'hA: t = LIC_TEST_LINE_IMP_AC;
         4'hC: t = LIC_TEST_RING_CURRENT;
         4'hD: t = LIC_TEST_METER_PULSE;
         4'hE: t = LIC_TEST_METER_FILTER;
         4'hF: t = LIC_TEST_CURRENT_LIMIT;
         default: t = LIC_TEST_NONE;
      endcase
      test_decode = t;
   endfunction

   // ---------------- register access ----------------
   assign wr_hit = cmd.wr && in_bank(cmd.addr);
   assign wr_idx = bank_idx(cmd.addr);
   assign rd_hit = in_bank(cmd.addr);
   assign rd_idx = bank_idx(cmd.addr);

   // reserved test bits are stored as written; software must keep them at zero
   generate
      for (genvar g = 0; g < LIC_NUM_REGS; g++) begin : g_bank
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               bank_reg[g] <= rst_value(g);
            end else if (wr_hit && (wr_idx == 3'(g))) begin
               bank_reg[g] <= cmd.wdata;
            end
         end
      end
   endgenerate

   // status read takes precedence over a register read in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data_reg  <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= status_rd || cmd.rd;
         if (status_rd) begin
            rd_data_reg <= status_byte;
         end else if (cmd.rd) begin
            rd_data_reg <= rd_hit ? bank_reg[rd_idx] : 8'h00;
         end
      end
   end

   // ---------------- decoded configuration ----------------
   always_ff @(posedge sys_clk) begin
      logic [3:0]  rt;
      logic [5:0]  al;
      logic [5:0]  sl;
      logic [2:0]  fr;
      logic [3:0]  rs;
      logic [2:0]  rf;
      logic [7:0]  ml;
      logic [3:0]  et;
      logic [21:0] mprod;
      rt    = bank_reg[0][LIC_POS_RTRIP_LSB +: 4];
      al    = bank_reg[1][LIC_POS_ALIM_LSB +: 6];
      sl    = bank_reg[2][LIC_POS_SLIM_LSB +: 6];
      fr    = bank_reg[3][LIC_POS_FEED_LSB +: 3];
      rs    = bank_reg[4][LIC_POS_RSTEP_LSB +: 4];
      rf    = bank_reg[4][LIC_POS_RFREQ_LSB +: 3];
      ml    = bank_reg[5];
      et    = bank_reg[6][LIC_POS_EXT_LSB +: 4];
      mprod = 22'(ml) * 22'(LIC_METER_FULL_MV);
      if (srst) begin
         cfg_reg <= '0;
      end else begin
         cfg_reg.ring_trip_ua       <= 16'(rt + 5'd1) * LIC_RTRIP_STEP_UA;
         cfg_reg.test_mode          <= test_decode(bank_reg[0][LIC_POS_TEST_LSB +: 4]);
         cfg_reg.test_code_unused   <= (bank_reg[0][LIC_POS_TEST_LSB +: 4] != 4'h0) &&
                                       (test_decode(bank_reg[0][LIC_POS_TEST_LSB +: 4])
                                        == LIC_TEST_NONE);
         cfg_reg.active_limit_100ua <= 10'(al) * LIC_LIMIT_STEP_100UA;
         cfg_reg.active_thr_100ua   <= bank_reg[1][LIC_POS_THRS] ? LIC_THR_HIGH_100UA
                                                                  : LIC_THR_LOW_100UA;
         cfg_reg.fixed_coefficient_sel <= bank_reg[1][LIC_POS_COEF_SRC];
         cfg_reg.standby_limit_100ua   <= 10'(sl) * LIC_LIMIT_STEP_100UA;
         cfg_reg.standby_state_sel     <= bank_reg[2][LIC_POS_PDDIS];
         cfg_reg.ring_trip_test_en     <= bank_reg[2][LIC_POS_RTEN];
         cfg_reg.feed_extra_ohm     <= 10'(fr + 4'd1) * LIC_FEED_STEP_OHM;
         cfg_reg.metering_khz       <= bank_reg[3][LIC_POS_MFREQ] ? LIC_MFREQ_HIGH_KHZ
                                                                  : LIC_MFREQ_LOW_KHZ;
         cfg_reg.metering_by_reversal <= bank_reg[3][LIC_POS_MREV];
         cfg_reg.soft_reversal_sel    <= bank_reg[3][LIC_POS_SOFTREV];
         cfg_reg.external_ring_source <= bank_reg[3][LIC_POS_EXTRING];
         cfg_reg.test_modulation_en   <= bank_reg[3][LIC_POS_TMM];
         if (bank_reg[4][LIC_POS_RRANGE]) begin
            cfg_reg.ring_amp_mvrms <= LIC_RING_BASE_HI_MV + 17'(rs) * LIC_RING_STEP_HI_MV;
         end else begin
            cfg_reg.ring_amp_mvrms <= LIC_RING_BASE_LO_MV + 17'(rs) * LIC_RING_STEP_LO_MV;
         end
         cfg_reg.ring_freq_unused <= (rf > 3'd4);
         unique case (rf)
            3'd0: cfg_reg.ring_freq_dhz <= 10'd166;
            3'd1: cfg_reg.ring_freq_dhz <= 10'd200;
            3'd2: cfg_reg.ring_freq_dhz <= 10'd250;
            3'd3: cfg_reg.ring_freq_dhz <= 10'd500;
            3'd4: cfg_reg.ring_freq_dhz <= 10'd600;
            default: cfg_reg.ring_freq_dhz <= 10'd0;
         endcase
         cfg_reg.meter_amp_mvrms <= 14'(mprod / 22'(LIC_METER_DIV));
         cfg_reg.meter_drop_mv   <= 15'(ml[7:3]) * 15'(LIC_DROP_STEP_MV);
         cfg_reg.ext_threshold_v <= (et == 4'h0) ? 5'd0 : LIC_EXT_BASE_V + 5'(et);
         cfg_reg.rx_highpass_disable <= bank_reg[6][LIC_POS_RXHP];
         cfg_reg.rx_companded_sel    <= bank_reg[7][LIC_POS_RX_CODE];
         cfg_reg.tx_companded_sel    <= bank_reg[7][LIC_POS_TX_CODE];
      end
   end

   // the coding-law bit belongs to the neighbouring bank; it arrives on the write port too
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_a_law_reg <= 1'b1;
      end else if (cmd.wr && (cmd.addr == 4'h4)) begin
         ext_a_law_reg <= cmd.wdata[0];
      end
   end

   // threshold compared against the registered setting, so one cycle behind a write
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         loop_ind_reg <= 1'b0;
      end else begin
         loop_ind_reg <= loop_current_100ua > cfg_reg.active_thr_100ua;
      end
   end

   // ---------------- signalling event logic ----------------
   assign mask_now    = bank_reg[7][LIC_POS_MASK_LSB +: SIG_W];
   assign mask_next   = cmd.wdata[LIC_POS_MASK_LSB +: SIG_W];
   assign mask_change = wr_hit && (wr_idx == 3'd7) && (mask_next != mask_now);
   assign enabled     = ~mask_now;
   assign sig_event   = |((sig_live ^ sig_prev_reg) & enabled);
   assign shadow_differs = ((sig_live ^ shadow_reg) & enabled) != '0;
   assign status_byte = {(shadow_reg & enabled) | (sig_live & mask_now), 2'b00};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sig_prev_reg <= sig_live;
      end else begin
         sig_prev_reg <= sig_live;
      end
   end

   // a mask change outranks a read and an event in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ev_state_reg <= LIC_EV_ARMED;
         shadow_reg   <= sig_live;
         hold_cnt_reg <= 2'd0;
      end else if (mask_change) begin
         ev_state_reg <= LIC_EV_ARMED;
         shadow_reg   <= sig_live;
         hold_cnt_reg <= 2'd0;
      end else if (status_rd) begin
         hold_cnt_reg <= 2'd0;
         if (shadow_differs) begin
            shadow_reg   <= sig_live;
            ev_state_reg <= LIC_EV_HOLD;
         end else begin
            ev_state_reg <= LIC_EV_ARMED;
         end
      end else begin
         unique case (ev_state_reg)
            LIC_EV_ARMED: begin
               if (sig_event) begin
                  shadow_reg   <= sig_live;
                  ev_state_reg <= LIC_EV_LATCHED;
               end
            end
            LIC_EV_LATCHED: begin
               ev_state_reg <= LIC_EV_LATCHED;
            end
            LIC_EV_HOLD: begin
               if (frame_tick) begin
                  if (hold_cnt_reg == LIC_HOLD_FRAMES - 2'd1) begin
                     ev_state_reg <= LIC_EV_LATCHED;
                     hold_cnt_reg <= 2'd0;
                  end else begin
                     hold_cnt_reg <= hold_cnt_reg + 2'd1;
                  end
               end
            end
            default: ev_state_reg <= LIC_EV_ARMED;
         endcase
      end
   end

   // registered copy, so no decode glitch of the state code reaches the link flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag_sys_reg <= 1'b0;
      end else begin
         flag_sys_reg <= (ev_state_reg == LIC_EV_LATCHED);
      end
   end

   // ---------------- link domain ----------------
   // reset is carried into the link domain as a level through two flops
   always_ff @(posedge link_clk) begin
      link_rst_s1_reg <= srst;
      link_rst_reg    <= link_rst_s1_reg;
   end

   // one toggle per frame start; a toggle survives the rate change, a pulse would not
   always_ff @(posedge link_clk) begin
      if (link_rst_reg) begin
         fsync_prev_reg <= 1'b0;
         frame_tgl_reg  <= 1'b0;
      end else begin
         fsync_prev_reg <= link_frame_sync;
         if (link_frame_sync && !fsync_prev_reg) begin
            frame_tgl_reg <= ~frame_tgl_reg;
         end
      end
   end

   // flag level into the link domain; it only changes once per read, mask change, event or end of a hold
   always_ff @(posedge link_clk) begin
      if (link_rst_reg) begin
         flag_s1_reg  <= 1'b0;
         flag_s2_reg  <= 1'b0;
         upstream_reg <= 1'b0;
      end else begin
         flag_s1_reg  <= flag_sys_reg;
         flag_s2_reg  <= flag_s1_reg;
         upstream_reg <= flag_s2_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
      end else begin
         tgl_s1_reg <= frame_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   assign frame_tick = tgl_s2_reg ^ tgl_s3_reg;

   // ---------------- outputs ----------------
   assign rd_data             = rd_data_reg;
   assign rd_valid            = rd_valid_reg;
   assign cfg                 = cfg_reg;
   assign a_law_sel           = ext_a_law_reg;
   assign loop_indication     = loop_ind_reg;
   assign change_flag         = (ev_state_reg == LIC_EV_LATCHED);
   assign upstream_change_bit = upstream_reg;

endmodule // lic_line_cfg

// ==== inc/lic_pkg.sv ====
// package: register map, reset values, field positions and decoded types of the line config bank
package lic_pkg;

   // register numbers as carried in the serial register commands
   localparam logic [3:0] LIC_REG_RING_TRIP_TEST   = 4'h5;
   localparam logic [3:0] LIC_REG_ACTIVE_LIMIT     = 4'h6;
   localparam logic [3:0] LIC_REG_STANDBY_LIMIT    = 4'h7;
   localparam logic [3:0] LIC_REG_FEED_METER       = 4'h8;
   localparam logic [3:0] LIC_REG_RING_FREQ_AMP    = 4'h9;
   localparam logic [3:0] LIC_REG_METER_LEVEL      = 4'hA;
   localparam logic [3:0] LIC_REG_EXT_IND          = 4'hB;
   localparam logic [3:0] LIC_REG_SIG_MASK_CODING  = 4'hC;
   localparam int         LIC_NUM_REGS             = 8;

   // reset values, in bank order
   localparam logic [7:0] LIC_RST_RING_TRIP_TEST   = 8'h60;
   localparam logic [7:0] LIC_RST_ACTIVE_LIMIT     = 8'h51;
   localparam logic [7:0] LIC_RST_STANDBY_LIMIT    = 8'h1C;
   localparam logic [7:0] LIC_RST_FEED_METER       = 8'h00;
   localparam logic [7:0] LIC_RST_RING_FREQ_AMP    = 8'h2F;
   localparam logic [7:0] LIC_RST_METER_LEVEL      = 8'hFF;
   localparam logic [7:0] LIC_RST_EXT_IND          = 8'h10;
   localparam logic [7:0] LIC_RST_SIG_MASK_CODING  = 8'hFF;

   // field positions
   localparam int LIC_POS_RTRIP_LSB     = 4;
   localparam int LIC_POS_TEST_LSB      = 0;
   localparam int LIC_POS_ALIM_LSB      = 2;
   localparam int LIC_POS_THRS          = 1;
   localparam int LIC_POS_COEF_SRC      = 0;
   localparam int LIC_POS_SLIM_LSB      = 2;
   localparam int LIC_POS_PDDIS         = 1;
   localparam int LIC_POS_RTEN          = 0;
   localparam int LIC_POS_FEED_LSB      = 5;
   localparam int LIC_POS_MFREQ         = 4;
   localparam int LIC_POS_MREV          = 3;
   localparam int LIC_POS_SOFTREV       = 2;
   localparam int LIC_POS_EXTRING       = 1;
   localparam int LIC_POS_TMM           = 0;
   localparam int LIC_POS_RRANGE        = 7;
   localparam int LIC_POS_RFREQ_LSB     = 4;
   localparam int LIC_POS_RSTEP_LSB     = 0;
   localparam int LIC_POS_EXT_LSB       = 4;
   localparam int LIC_POS_TSTB          = 3;
   localparam int LIC_POS_TSTA          = 2;
   localparam int LIC_POS_RXHP          = 1;
   localparam int LIC_POS_MASK_LSB      = 2;
   localparam int LIC_POS_RX_CODE       = 1;
   localparam int LIC_POS_TX_CODE       = 0;
   localparam int LIC_NUM_SIG           = 6;

   // analog scaling, in the output units below
   localparam logic [15:0] LIC_RTRIP_STEP_UA    = 16'd600;   // 9.6/16 mA
   localparam logic [9:0]  LIC_LIMIT_STEP_100UA = 10'd11;    // 1.1 mA
   localparam logic [9:0]  LIC_THR_LOW_100UA    = 10'd100;   // 10 mA
   localparam logic [9:0]  LIC_THR_HIGH_100UA   = 10'd130;   // 13 mA
   localparam logic [9:0]  LIC_FEED_STEP_OHM    = 10'd100;   // 2 x 50 ohm
   localparam logic [4:0]  LIC_MFREQ_LOW_KHZ    = 5'd16;
   localparam logic [4:0]  LIC_MFREQ_HIGH_KHZ   = 5'd12;
   localparam logic [16:0] LIC_RING_BASE_LO_MV  = 17'd34400;
   localparam logic [16:0] LIC_RING_STEP_LO_MV  = 17'd2039;
   localparam logic [16:0] LIC_RING_BASE_HI_MV  = 17'd45000;
   localparam logic [16:0] LIC_RING_STEP_HI_MV  = 17'd2660;
   localparam logic [17:0] LIC_METER_FULL_MV    = 18'd10000;
   localparam logic [17:0] LIC_METER_DIV        = 18'd255;
   localparam logic [9:0]  LIC_DROP_STEP_MV     = 10'd600;   // 15 mV x 40
   localparam logic [4:0]  LIC_EXT_BASE_V       = 5'd8;
   localparam logic [1:0]  LIC_HOLD_FRAMES      = 2'd2;

   typedef enum logic [3:0] {
      LIC_TEST_NONE,
      LIC_TEST_LEAK,
      LIC_TEST_LEAK_ALT,
      LIC_TEST_800HZ,
      LIC_TEST_TONE_CAL,
      LIC_TEST_ANALOG_LOOP,
      LIC_TEST_LINE_IMP_DC,
      LIC_TEST_LINE_IMP_AC,
      LIC_TEST_RING_CURRENT,
      LIC_TEST_METER_PULSE,
      LIC_TEST_METER_FILTER,
      LIC_TEST_CURRENT_LIMIT
   } lic_test_t;

   // decoded configuration, all values from flip-flops
   typedef struct packed {
      logic [15:0] ring_trip_ua;
      lic_test_t   test_mode;
      logic        test_code_unused;
      logic [9:0]  active_limit_100ua;
      logic [9:0]  active_thr_100ua;
      logic        fixed_coefficient_sel;
      logic [9:0]  standby_limit_100ua;
      logic        standby_state_sel;
      logic        ring_trip_test_en;
      logic [9:0]  feed_extra_ohm;
      logic [4:0]  metering_khz;
      logic        metering_by_reversal;
      logic        soft_reversal_sel;
      logic        external_ring_source;
      logic        test_modulation_en;
      logic [16:0] ring_amp_mvrms;
      logic [9:0]  ring_freq_dhz;
      logic        ring_freq_unused;
      logic [13:0] meter_amp_mvrms;
      logic [14:0] meter_drop_mv;
      logic [4:0]  ext_threshold_v;
      logic        rx_highpass_disable;
      logic        rx_companded_sel;
      logic        tx_companded_sel;
   } lic_cfg_t;

   // register command from the serial command decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } lic_cmd_t;

endpackage : lic_pkg

// ==== test/lic_line_cfg_asserts.sv ====
// checker: timing and decode relations at the line config bank ports
module lic_line_cfg_asserts
   import lic_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              srst,
   input wire lic_pkg::lic_cmd_t cmd,
   input wire logic              status_rd,
   input wire logic              rd_valid,
   input wire lic_pkg::lic_cfg_t cfg,
   input wire logic              a_law_sel,
   input wire logic              change_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic       wr_c;
   logic [5:0] mask_reg;
   assign wr_c = cmd.wr && cmd.addr == LIC_REG_SIG_MASK_CODING;
   // own copy of the mask so that only real mask changes are judged
   always_ff @(posedge sys_clk) begin
      if (srst) mask_reg <= 6'h3F;
      else if (wr_c) mask_reg <= cmd.wdata[7:2];
   end
   a_rd_valid_pulse: assert property (##1 rd_valid == $past(cmd.rd || status_rd))
      else $error("read valid timing wrong");
   a_law_write: assert property ((cmd.wr && cmd.addr == 4'h4) |=> a_law_sel == $past(cmd.wdata[0]))
      else $error("coding law not taken");
   a_flag_frozen: assert property ((change_flag && !status_rd && !wr_c) |=> change_flag)
      else $error("flag dropped without read");
   a_read_clears: assert property (status_rd |=> !change_flag)
      else $error("flag not cleared by status read");
   a_mask_clears: assert property ((wr_c && cmd.wdata[7:2] != mask_reg) |=> !change_flag)
      else $error("mask change kept flag");
   a_thr_decode: assert property ((cmd.wr && cmd.addr == LIC_REG_ACTIVE_LIMIT) |=> ##1
      cfg.active_thr_100ua == ($past(cmd.wdata[1], 2) ? LIC_THR_HIGH_100UA : LIC_THR_LOW_100UA))
      else $error("threshold decode wrong");
   a_limit_decode: assert property ((cmd.wr && cmd.addr == LIC_REG_ACTIVE_LIMIT) |=> ##1
      cfg.active_limit_100ua == 10'($past(cmd.wdata[7:2], 2)) * LIC_LIMIT_STEP_100UA)
      else $error("limit decode wrong");
   a_ext_decode: assert property ((cmd.wr && cmd.addr == LIC_REG_EXT_IND) |=> ##1
      cfg.ext_threshold_v == ($past(cmd.wdata[7:4], 2) == 4'h0 ? 5'd0 :
      LIC_EXT_BASE_V + 5'($past(cmd.wdata[7:4], 2))))
      else $error("external threshold decode wrong");
endmodule // lic_line_cfg_asserts

bind lic_line_cfg lic_line_cfg_asserts lic_line_cfg_asserts_i (.sys_clk(sys_clk), .srst(srst),
   .cmd(cmd), .status_rd(status_rd), .rd_valid(rd_valid), .cfg(cfg), .a_law_sel(a_law_sel),
   .change_flag(change_flag));

// ==== test/lic_link_model.sv ====
// link side model: free running link clock and one-cycle frame starts
module lic_link_model #(
   parameter int FRAME_LEN = 8
) (
   output logic link_clk,
   output logic link_frame_sync
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // short frames keep the two-frame hold quick to observe
   initial begin
      link_clk = 1'b0;
      link_frame_sync = 1'b0;
      #1;
      forever #40 link_clk = ~link_clk;
   end
   always @(posedge link_clk) begin
      cnt <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
      link_frame_sync <= (cnt == 0);
   end
endmodule // lic_link_model

// ==== test/tb.sv ====
// self-checking bench for the line config bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lic_pkg::*;
   logic       sys_clk = 1'b0, srst = 1'b1, status_rd = 1'b0;
   lic_cmd_t   cmd = '0;
   logic [5:0] sig_live = 6'h15;
   logic [9:0] loop_cur = 10'd0;
   logic [7:0] rd_data, got;
   logic       rd_valid, a_law_sel, loop_ind, change_flag, link_clk, link_fs, up_bit;
   lic_cfg_t   cfg;
   logic [15:0] seed = 16'd7792;
   int         bad_count = 0, compares = 0;
   logic [7:0] rst_tab [8] = '{8'h60, 8'h51, 8'h1C, 8'h00, 8'h2F, 8'hFF, 8'h10, 8'hFF};
   int         rf_tab [8] = '{166, 200, 250, 500, 600, 0, 0, 0};

   initial forever #20 sys_clk = ~sys_clk;

   lic_link_model lic_link_model_i (.link_clk(link_clk), .link_frame_sync(link_fs));
   lic_line_cfg lic_line_cfg_i (.sys_clk(sys_clk), .srst(srst), .cmd(cmd), .status_rd(status_rd),
      .sig_live(sig_live), .loop_current_100ua(loop_cur), .rd_data(rd_data), .rd_valid(rd_valid),
      .cfg(cfg), .a_law_sel(a_law_sel), .loop_indication(loop_ind), .change_flag(change_flag),
      .link_clk(link_clk), .link_frame_sync(link_fs), .upstream_change_bit(up_bit));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] exp_f(input logic [3:0] a, input logic [7:0] d);
      case (a)
         4'h5: return (d[7:4] + 32'd1) * 32'd600;
         4'h6, 4'h7: return d[7:2] * 32'd11;
         4'h8: return (d[7:5] + 32'd1) * 32'd100;
         4'h9: return d[7] ? 45000 + d[3:0] * 2660 : 34400 + d[3:0] * 2039;
         4'hA: return d[7:3] * 32'd600;
         default: return (d[7:4] == 4'h0) ? 32'd0 : 32'd8 + d[7:4];
      endcase
   endfunction
   function automatic logic [31:0] got_f(input logic [3:0] a);
      case (a)
         4'h5: return 32'(cfg.ring_trip_ua);
         4'h6: return 32'(cfg.active_limit_100ua);
         4'h7: return 32'(cfg.standby_limit_100ua);
         4'h8: return 32'(cfg.feed_extra_ohm);
         4'h9: return 32'(cfg.ring_amp_mvrms);
         4'hA: return 32'(cfg.meter_drop_mv);
         default: return 32'(cfg.ext_threshold_v);
      endcase
   endfunction
   function automatic logic [31:0] exp_g(input logic [3:0] a, input logic [7:0] d);
      case (a)
         4'h5: return 32'(16'h0948 >> d[3:0]) & 32'd1;
         4'h6: return {21'd0, (d[1] ? 10'd130 : 10'd100), d[0]};
         4'h7: return 32'(d[1:0]);
         4'h8: return {23'd0, (d[4] ? 5'd12 : 5'd16), d[3:0]};
         4'h9: return {21'd0, 10'(rf_tab[d[6:4]]), (d[6:4] > 3'd4)};
         4'hA: return 32'd10000 * d / 32'd255;
         default: return 32'(d[1]);
      endcase
   endfunction
   function automatic logic [31:0] got_g(input logic [3:0] a);
      case (a)
         4'h5: return 32'(cfg.test_code_unused);
         4'h6: return 32'({cfg.active_thr_100ua, cfg.fixed_coefficient_sel});
         4'h7: return 32'({cfg.standby_state_sel, cfg.ring_trip_test_en});
         4'h8: return 32'({cfg.metering_khz, cfg.metering_by_reversal, cfg.soft_reversal_sel,
                           cfg.external_ring_source, cfg.test_modulation_en});
         4'h9: return 32'({cfg.ring_freq_dhz, cfg.ring_freq_unused});
         4'hA: return 32'(cfg.meter_amp_mvrms);
         default: return 32'(cfg.rx_highpass_disable);
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) cmd <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) cmd <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic st);
      @(posedge sys_clk);
      if (st) status_rd <= 1'b1;
      else cmd <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      status_rd <= 1'b0;
      cmd <= '0;
      #1 chk("rd_valid", 1, rd_valid);
      got = rd_data;
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      end_sim;
   end

   initial begin
      logic [3:0] a;
      logic [7:0] d, ev;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 5; i <= 12; i++) begin
         rd(4'(i), 1'b0);
         chk("reset value", rst_tab[i-5], got);
      end
      rd(4'hD, 1'b0);
      chk("unmapped read", 0, got);
      $display("test reset values done");
      // corners 00 and FF first, then random codes
      for (int k = 0; k < 40; k++) begin
         seed = lfsr(seed);
         a = 4'(5 + seed[10:8] % 7);
         d = (k < 2) ? {8{k[0]}} : seed[15:8];
         if (a == LIC_REG_EXT_IND) d[3:2] = 2'b00;
         wr(a, d);
         rd(a, 1'b0);
         chk("read back", d, got);
         chk("decode", exp_f(a, d), got_f(a));
         chk("decode flags", exp_g(a, d), got_g(a));
      end
      $display("test random config done");
      wr(4'h5, 8'h09);
      tick(2);
      chk("test mode", LIC_TEST_LINE_IMP_DC, cfg.test_mode);
      wr(4'h5, 8'h08);
      tick(2);
      chk("unused test", 1, cfg.test_code_unused);
      wr(4'h4, 8'h00);
      tick(2);
      chk("coding law", 0, a_law_sel);
      wr(4'h6, 8'h02);
      loop_cur <= 10'd140;
      tick(4);
      chk("loop above", 1, loop_ind);
      loop_cur <= 10'd125;
      tick(4);
      chk("loop below", 0, loop_ind);
      $display("test decode corners done");
      wr(4'hC, 8'h03);
      tick(2);
      chk("coding", 2'b11, {cfg.rx_companded_sel, cfg.tx_companded_sel});
      chk("flag idle", 0, change_flag);
      ev = {sig_live ^ 6'h20, 2'b00};
      @(posedge sys_clk) sig_live <= sig_live ^ 6'h20;
      for (int i = 0; i < 20 && change_flag !== 1'b1; i++) @(posedge sys_clk);
      chk("flag set", 1, change_flag);
      sig_live <= sig_live ^ 6'h10;
      tick(3);
      chk("flag frozen", 1, change_flag);
      rd(4'h0, 1'b1);
      chk("status shadow", ev, got);
      tick(3);
      chk("flag held low", 0, change_flag);
      for (int i = 0; i < 300 && change_flag !== 1'b1; i++) @(posedge sys_clk);
      chk("flag again", 1, change_flag);
      for (int i = 0; i < 40 && up_bit !== 1'b1; i++) @(posedge sys_clk);
      chk("upstream bit", 1, up_bit);
      // hook masked: its toggle raises nothing and reads live
      wr(4'hC, 8'h83);
      tick(2);
      chk("mask relatch", 0, change_flag);
      @(posedge sys_clk) sig_live <= sig_live ^ 6'h20;
      tick(10);
      chk("masked quiet", 0, change_flag);
      rd(4'h0, 1'b1);
      chk("status live", {sig_live, 2'b00}, got);
      $display("test signalling events done");
      end_sim;
   end
endmodule // tb
